// ---- src/erase_seq_defs.svh ----
// timing counts, opcodes and field positions for the erase sequencer
// assumes a 25 MHz system clock and a 4 MB array
`ifndef ERASE_SEQ_DEFS_SVH
`define ERASE_SEQ_DEFS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_RD_STATUS 8'h05
`define OP_SECT_ERASE 8'h20
`define OP_HALF_ERASE 8'h52
`define OP_FULL_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'hC7
`define OP_CHIP_ERASE_B 8'h60
`define OP_PAUSE 8'h75
`define OP_RESUME 8'h7A

// ----------------------------------------------------------------
// frame lengths in bits
// ----------------------------------------------------------------
`define BITS_OPCODE 6'h08
`define BITS_ADDR_CMD 6'h20

// ----------------------------------------------------------------
// array geometry, region sizes as log2 of bytes
// ----------------------------------------------------------------
`define MEM_AW 22
`define SECT_LOG2 5'h0C
`define HALF_LOG2 5'h0F
`define FULL_LOG2 5'h10

// ----------------------------------------------------------------
// status byte bit positions
// ----------------------------------------------------------------
`define ST_BUSY 0
`define ST_WR_LATCH 1
`define ST_BP_LO 2
`define ST_FROM_BOT 5
`define ST_GRAN 6
`define ST_PAUSE_BIT 7

// ----------------------------------------------------------------
// times in their own units, clock rate, derived cycle counts
// ----------------------------------------------------------------
`define MCLK_MHZ 25
`define SECT_ERASE_TIME_US 30
`define HALF_BLOCK_ERASE_TIME_US 120
`define FULL_BLOCK_ERASE_TIME_US 150
`define WHOLE_ARRAY_ERASE_TIME_US 10000
`define PAUSE_LATENCY_US 20
`define RESUME_BUSY_NS 200
`define SECT_ERASE_CYC (`SECT_ERASE_TIME_US * `MCLK_MHZ)
`define HALF_ERASE_CYC (`HALF_BLOCK_ERASE_TIME_US * `MCLK_MHZ)
`define FULL_ERASE_CYC (`FULL_BLOCK_ERASE_TIME_US * `MCLK_MHZ)
`define CHIP_ERASE_CYC (`WHOLE_ARRAY_ERASE_TIME_US * `MCLK_MHZ)
`define PAUSE_LATENCY_CYC (`PAUSE_LATENCY_US * `MCLK_MHZ)
`define RESUME_BUSY_CYC ((`RESUME_BUSY_NS * `MCLK_MHZ) / 1000)

`endif

// ---- src/erase_seq_pkg.sv ----
// types shared by the erase sequencer and its surroundings
// assumes erase_seq_defs.svh for the widths
package erase_seq_pkg;

  // ----------------------------------------------------------------
  // erase region kinds and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_SECT = 2'b00,
    KIND_HALF = 2'b01,
    KIND_FULL = 2'b10,
    KIND_CHIP = 2'b11
  } erase_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PAUSING = 2'b10,
    ST_PAUSED = 2'b11
  } seq_state_e;

  // ----------------------------------------------------------------
  // protection settings and array erase command
  // ----------------------------------------------------------------
  typedef struct packed {
    logic protect_granularity_bit;
    logic protect_from_bottom_bit;
    logic block_protect_hi;
    logic block_protect_mid;
    logic block_protect_lo;
  } protect_cfg_s;

  typedef struct packed {
    logic active;
    erase_kind_e kind;
    logic [23:0] base;
  } erase_cmd_s;

endpackage : erase_seq_pkg

// ---- src/serial_flash_erase_suspend.sv ----
// erase and erase pause/resume command logic of a serial flash
// assumes spi mode 0 from the host, pins asynchronous to mclk_i,
// and an array that erases the region shown on erase_cmd_o while active
//
// Function
// - opcode 20h plus 24-bit address erases the addressed 4 KB sector
// - opcode 52h plus 24-bit address erases the addressed 32 KB block
// - opcode D8h plus 24-bit address erases the addressed 64 KB block
// - opcode C7h or 60h, no address, erases the whole array
// - erase refused unless the write enable latch is set
// - erase discarded unless chip select rises right after the last byte
// - valid erase starts on chip select rise, busy high until done
// - read status stays available while erasing
// - write enable latch cleared when an erase completes
// - sector or block erase refused when its region is protected
// - whole array erase refused if any block protect bit is set
// - pause accepted only when not paused, busy, and sector/block erase
// - pause ignored during whole array erase or program
// - pause sets paused flag at once, busy falls within pause latency
// - no status write or erase while paused; other access allowed
// - resume clears paused flag at once, busy back within 200 ns
// - resume accepted only when paused and not busy
// - after power loss paused flag is clear, resume ignored
`timescale 1ns/1ps
`include "erase_seq_defs.svh"

module serial_flash_erase_suspend #(
  parameter int unsigned SECT_CYC = `SECT_ERASE_CYC,
  parameter int unsigned HALF_CYC = `HALF_ERASE_CYC,
  parameter int unsigned FULL_CYC = `FULL_ERASE_CYC,
  parameter int unsigned CHIP_CYC = `CHIP_ERASE_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // spi pins from the host
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_n_o,
  // protection settings
  input wire erase_seq_pkg::protect_cfg_s protect_cfg_i,
  // array side and status
  output erase_seq_pkg::erase_cmd_s erase_cmd_o,
  output logic busy_o,
  output logic write_enable_latch_o,
  output logic erase_paused_flag_o
);

  localparam int PAUSE_CYC_I = `PAUSE_LATENCY_CYC;
  localparam int RESUME_CYC_I = `RESUME_BUSY_CYC;
  localparam logic [31:0] PAUSE_CYC = 32'(`PAUSE_LATENCY_CYC);

  // ----------------------------------------------------------------
  // pin sampling: three flops, change counts when 2nd and 3rd agree
  // ----------------------------------------------------------------
  logic [2:0] sy1;
  logic [2:0] sy2;
  logic [2:0] sy3;
  logic [2:0] pin_f;
  logic [2:0] pin_d;
  logic [2:0] pin_raw;

  assign pin_raw = {spi_mosi_i, spi_sclk_i, spi_cs_n_i};

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sy1 <= 3'h1;
      sy2 <= 3'h1;
      sy3 <= 3'h1;
      pin_f <= 3'h1;
      pin_d <= 3'h1;
    end else begin
      sy1 <= pin_raw;
      sy2 <= sy1;
      sy3 <= sy2;
      for (int i = 0; i < 3; i++) begin
        if (sy2[i] == sy3[i]) begin
          pin_f[i] <= sy3[i];
        end
      end
      pin_d <= pin_f;
    end
  end

  logic cs_n;
  logic mosi;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  assign cs_n = pin_f[0];
  assign mosi = pin_f[2];
  assign cs_fall = pin_d[0] & ~pin_f[0];
  assign cs_rise = ~pin_d[0] & pin_f[0];
  assign sclk_rise = ~cs_n & ~pin_d[1] & pin_f[1];
  assign sclk_fall = ~cs_n & pin_d[1] & ~pin_f[1];

  // ----------------------------------------------------------------
  // frame shifter and bit count
  // ----------------------------------------------------------------
  logic [31:0] shreg;
  logic [5:0] bitcnt;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      shreg <= 32'h0000_0000;
      bitcnt <= 6'h00;
    end else if (cs_fall) begin
      bitcnt <= 6'h00;
    end else if (sclk_rise) begin
      shreg <= {shreg[30:0], mosi};
      if (bitcnt != 6'h3F) begin
        bitcnt <= bitcnt + 6'h01;
      end
    end
  end

  // opcode is the first byte; position depends on frame length
  logic [7:0] opcode;
  logic [23:0] addr;
  logic len_op;
  logic len_addr;

  assign len_op = (bitcnt == `BITS_OPCODE);
  assign len_addr = (bitcnt == `BITS_ADDR_CMD);
  assign opcode = len_addr ? shreg[31:24] : shreg[7:0];
  assign addr = shreg[23:0];

  // ----------------------------------------------------------------
  // protection check
  // ----------------------------------------------------------------
  function automatic logic prot_hit(
    input erase_seq_pkg::protect_cfg_s cfg,
    input logic [23:0] base,
    input erase_seq_pkg::erase_kind_e kind
  );
    logic [2:0] bp;
    logic [4:0] plog;
    logic [4:0] rlog;
    logic [24:0] plen;
    logic [24:0] rstart;
    logic [24:0] rend;
    logic [24:0] msize;
    bp = {cfg.block_protect_hi, cfg.block_protect_mid,
          cfg.block_protect_lo};
    msize = 25'h1 << `MEM_AW;
    unique case (kind)
      erase_seq_pkg::KIND_SECT: rlog = `SECT_LOG2;
      erase_seq_pkg::KIND_HALF: rlog = `HALF_LOG2;
      default: rlog = `FULL_LOG2;
    endcase
    if (cfg.protect_granularity_bit) begin
      plog = (bp >= 3'h4) ? `HALF_LOG2 : 5'(`SECT_LOG2 + 5'(bp) - 5'h01);
    end else begin
      plog = 5'(`FULL_LOG2 + 5'(bp) - 5'h01);
    end
    plen = (bp == 3'h7) ? msize : 25'h1 << plog;
    // low address bits dropped, region from upper bits only
    rstart = {1'b0, base & ~((24'h1 << rlog) - 24'h1)};
    rstart = rstart & (msize - 25'h1);
    rend = rstart + (25'h1 << rlog);
    if (bp == 3'h0) begin
      prot_hit = 1'b0;
    end else if (cfg.protect_from_bottom_bit) begin
      prot_hit = rstart < plen;
    end else begin
      prot_hit = rend > (msize - plen);
    end
  endfunction : prot_hit

  logic bp_any;
  assign bp_any = protect_cfg_i.block_protect_hi |
                  protect_cfg_i.block_protect_mid |
                  protect_cfg_i.block_protect_lo;

  // ----------------------------------------------------------------
  // command decode at chip select rise
  // ----------------------------------------------------------------
  erase_seq_pkg::seq_state_e state;
  logic wr_latch;
  logic paused;
  logic busy;
  logic is_addr_erase;
  logic is_chip_erase;
  erase_seq_pkg::erase_kind_e dec_kind;
  logic erase_start;
  logic accept_pause;
  logic accept_resume;
  logic erase_done;

  assign busy = (state == erase_seq_pkg::ST_ERASE) |
                (state == erase_seq_pkg::ST_PAUSING);

  always_comb begin
    is_addr_erase = 1'b0;
    dec_kind = erase_seq_pkg::KIND_CHIP;
    unique case (opcode)
      `OP_SECT_ERASE: begin
        is_addr_erase = 1'b1;
        dec_kind = erase_seq_pkg::KIND_SECT;
      end
      `OP_HALF_ERASE: begin
        is_addr_erase = 1'b1;
        dec_kind = erase_seq_pkg::KIND_HALF;
      end
      `OP_FULL_ERASE: begin
        is_addr_erase = 1'b1;
        dec_kind = erase_seq_pkg::KIND_FULL;
      end
      default: begin
      end
    endcase
  end

  assign is_chip_erase = len_op & ((opcode == `OP_CHIP_ERASE_A) |
                                   (opcode == `OP_CHIP_ERASE_B));

  // a frame of the wrong length is silently dropped
  assign erase_start = cs_rise & ~busy & ~paused & wr_latch &
    ((len_addr & is_addr_erase &
      ~prot_hit(protect_cfg_i, addr, dec_kind)) |
     (is_chip_erase & ~bp_any));

  // a pause on the last erase cycle is dropped, else the flag would stick
  assign accept_pause = cs_rise & len_op & (opcode == `OP_PAUSE) &
    ~paused & ~erase_done & (state == erase_seq_pkg::ST_ERASE) &
    (erase_cmd_o.kind != erase_seq_pkg::KIND_CHIP);

  assign accept_resume = cs_rise & len_op & (opcode == `OP_RESUME) &
    paused & (state == erase_seq_pkg::ST_PAUSED);

  // ----------------------------------------------------------------
  // erase sequencer
  // ----------------------------------------------------------------
  logic [31:0] timer;
  logic [31:0] pause_cnt;

  function automatic logic [31:0] erase_cycles(
    input erase_seq_pkg::erase_kind_e kind
  );
    unique case (kind)
      erase_seq_pkg::KIND_SECT: erase_cycles = SECT_CYC;
      erase_seq_pkg::KIND_HALF: erase_cycles = HALF_CYC;
      erase_seq_pkg::KIND_FULL: erase_cycles = FULL_CYC;
      erase_seq_pkg::KIND_CHIP: erase_cycles = CHIP_CYC;
    endcase
  endfunction : erase_cycles

  assign erase_done = (state == erase_seq_pkg::ST_ERASE) &
                      (timer <= 32'h0000_0001);

  // reset stands for power loss: no paused erase survives it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= erase_seq_pkg::ST_IDLE;
      timer <= 32'h0000_0000;
      pause_cnt <= 32'h0000_0000;
      erase_cmd_o <= '0;
    end else begin
      unique case (state)
        erase_seq_pkg::ST_IDLE: begin
          if (erase_start) begin
            state <= erase_seq_pkg::ST_ERASE;
            timer <= erase_cycles(is_chip_erase ?
                                  erase_seq_pkg::KIND_CHIP : dec_kind);
            erase_cmd_o.active <= 1'b1;
            erase_cmd_o.kind <= is_chip_erase ?
                                erase_seq_pkg::KIND_CHIP : dec_kind;
            erase_cmd_o.base <= is_chip_erase ? 24'h00_0000 : addr;
          end
        end
        erase_seq_pkg::ST_ERASE: begin
          if (erase_done) begin
            state <= erase_seq_pkg::ST_IDLE;
            timer <= 32'h0000_0000;
            erase_cmd_o.active <= 1'b0;
          end else if (accept_pause) begin
            state <= erase_seq_pkg::ST_PAUSING;
            pause_cnt <= PAUSE_CYC;
            timer <= timer - 32'h0000_0001;
          end else begin
            timer <= timer - 32'h0000_0001;
          end
        end
        erase_seq_pkg::ST_PAUSING: begin
          // array is halted at once; busy drops at the latency bound
          erase_cmd_o.active <= 1'b0;
          if (pause_cnt <= 32'h0000_0001) begin
            state <= erase_seq_pkg::ST_PAUSED;
          end else begin
            pause_cnt <= pause_cnt - 32'h0000_0001;
          end
        end
        erase_seq_pkg::ST_PAUSED: begin
          if (accept_resume) begin
            state <= erase_seq_pkg::ST_ERASE;
            erase_cmd_o.active <= 1'b1;
          end
        end
      endcase
    end
  end

  // paused flag: set on an accepted pause, cleared on resume
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      paused <= 1'b0;
    end else if (accept_pause) begin
      paused <= 1'b1;
    end else if (accept_resume) begin
      paused <= 1'b0;
    end
  end

  // write enable latch; completion clear loses to nothing else here
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_latch <= 1'b0;
    end else if (erase_done) begin
      wr_latch <= 1'b0;
    end else if (cs_rise & len_op & ~busy) begin
      if (opcode == `OP_WR_ENABLE) begin
        wr_latch <= 1'b1;
      end else if (opcode == `OP_WR_DISABLE) begin
        wr_latch <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // status readout, served in every state
  // ----------------------------------------------------------------
  logic [7:0] status;
  logic [7:0] out_sh;
  logic rd_stat;

  always_comb begin
    status = 8'h00;
    status[`ST_BUSY] = busy;
    status[`ST_WR_LATCH] = wr_latch;
    status[`ST_BP_LO] = protect_cfg_i.block_protect_lo;
    status[`ST_BP_LO + 1] = protect_cfg_i.block_protect_mid;
    status[`ST_BP_LO + 2] = protect_cfg_i.block_protect_hi;
    status[`ST_FROM_BOT] = protect_cfg_i.protect_from_bottom_bit;
    status[`ST_GRAN] = protect_cfg_i.protect_granularity_bit;
    status[`ST_PAUSE_BIT] = paused;
  end

  // byte reloads every 8 link clock bits, then on every bit once bitcnt saturates at 63, so a poll of up to 7 status bytes sees live busy
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rd_stat <= 1'b0;
      out_sh <= 8'h00;
      spi_miso_o <= 1'b0;
    end else if (cs_n) begin
      rd_stat <= 1'b0;
    end else if (sclk_rise && bitcnt[2:0] == 3'h7) begin
      if (rd_stat || (bitcnt == 6'h07 &&
                      {shreg[6:0], mosi} == `OP_RD_STATUS)) begin
        rd_stat <= 1'b1;
        out_sh <= status;
      end
    end else if (sclk_fall && rd_stat) begin
      spi_miso_o <= out_sh[7];
      out_sh <= {out_sh[6:0], 1'b0};
    end
  end

  assign spi_miso_oe_n_o = ~rd_stat;
  assign busy_o = busy;
  assign write_enable_latch_o = wr_latch;
  assign erase_paused_flag_o = paused;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_pause_taken;
    accept_pause ##1 paused;
  endsequence

  sequence s_busy_drop;
    ##[1:PAUSE_CYC_I] !busy;
  endsequence

  property p_pause_latency;
    @(posedge mclk_i) disable iff (sys_rst_i)
      s_pause_taken |-> s_busy_drop;
  endproperty
  a_pause_latency: assert property (p_pause_latency)
    else $error("busy did not fall within pause latency");

  property p_pause_guard;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(paused) |-> busy && $past(busy) &&
        erase_cmd_o.kind != erase_seq_pkg::KIND_CHIP;
  endproperty
  a_pause_guard: assert property (p_pause_guard)
    else $error("pause accepted in wrong state");

  property p_resume;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept_resume |-> (paused && !busy)
        ##[1:RESUME_CYC_I] (!paused && busy);
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not restore busy in time");

  property p_resume_guard;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $fell(paused) |-> busy && $past(state) == erase_seq_pkg::ST_PAUSED;
  endproperty
  a_resume_guard: assert property (p_resume_guard)
    else $error("resume accepted while not paused");

  property p_latch_done;
    @(posedge mclk_i) disable iff (sys_rst_i)
      erase_done |=> !wr_latch && !busy;
  endproperty
  a_latch_done: assert property (p_latch_done)
    else $error("write enable latch kept after erase");

  property p_start_needs_latch;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(erase_cmd_o.active) && !paused && !$past(paused) |->
        $past(wr_latch) && $past(cs_rise);
  endproperty
  a_start_needs_latch: assert property (p_start_needs_latch)
    else $error("erase started without write enable or cs rise");

  property p_busy_held;
    @(posedge mclk_i) disable iff (sys_rst_i)
      erase_start |=> busy [*2];
  endproperty
  a_busy_held: assert property (p_busy_held)
    else $error("busy not raised by erase start");

  property p_chip_prot;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(erase_cmd_o.active) &&
        erase_cmd_o.kind == erase_seq_pkg::KIND_CHIP |-> !$past(bp_any);
  endproperty
  a_chip_prot: assert property (p_chip_prot)
    else $error("whole array erase with protection set");

  property p_frame_len;
    @(posedge mclk_i) disable iff (sys_rst_i)
      erase_start |-> (len_addr && is_addr_erase) || is_chip_erase;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("erase started from a frame of wrong length");

  property p_no_erase_paused;
    @(posedge mclk_i) disable iff (sys_rst_i)
      paused && !accept_resume |=>
        $stable(erase_cmd_o.base) && $stable(erase_cmd_o.kind);
  endproperty
  a_no_erase_paused: assert property (p_no_erase_paused)
    else $error("erase started while paused");

endmodule : serial_flash_erase_suspend

// ---- tb/host_spi_model.sv ----
// host spi controller model, mode 0, 320 ns link clock
// assumes a 40 ns mclk_i; close_f spaces frames by 12 clocks before returning
`timescale 1ns/1ps

module host_spi_model (
  // clock
  input wire logic mclk_i,
  // spi pins
  output logic spi_cs_n_o,
  output logic spi_sclk_o,
  output logic spi_mosi_o,
  input wire logic spi_miso_i
);
  logic [7:0] rx = 8'h00;

  // link clock stands low outside frames
  initial begin
    spi_cs_n_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_mosi_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wait_clk

  // ----------------------------------------------------------------
  // bit and frame framing
  // ----------------------------------------------------------------
  task automatic put_bit(input logic b);
    spi_sclk_o <= 1'b0;
    spi_mosi_o <= b;
    wait_clk(4);
    spi_sclk_o <= 1'b1;
    // sample mid high phase, well clear of the filtered fall
    wait_clk(2);
    rx <= {rx[6:0], spi_miso_i};
    wait_clk(2);
  endtask : put_bit

  task automatic open_f();
    @(posedge mclk_i);
    spi_cs_n_o <= 1'b0;
    wait_clk(4);
  endtask : open_f

  task automatic close_f();
    spi_sclk_o <= 1'b0;
    wait_clk(2);
    spi_cs_n_o <= 1'b1;
    // released line must not keep the last bit
    spi_mosi_o <= ~spi_mosi_o;
    wait_clk(12);
  endtask : close_f

  // ----------------------------------------------------------------
  // frames
  // ----------------------------------------------------------------
  task automatic send8(input logic [7:0] v);
    open_f();
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    close_f();
  endtask : send8

  task automatic send24(input logic [23:0] v);
    open_f();
    for (int i = 23; i >= 0; i--) put_bit(v[i]);
    close_f();
  endtask : send24

  task automatic send32(input logic [31:0] v);
    open_f();
    for (int i = 31; i >= 0; i--) put_bit(v[i]);
    close_f();
  endtask : send32

  task automatic read_status(output logic [7:0] st);
    logic [7:0] op;
    op = 8'h05;
    open_f();
    for (int i = 7; i >= 0; i--) put_bit(op[i]);
    for (int i = 7; i >= 0; i--) put_bit(1'b0);
    close_f();
    st = rx;
  endtask : read_status
endmodule : host_spi_model

// ---- tb/serial_flash_erase_suspend_test.sv ----
// testbench for the erase sequencer: erase table, then pause cases
// assumes host_spi_model on the spi pins and erase times of 2000 to 3200 cycles
`timescale 1ns/1ps

module serial_flash_erase_suspend_test;
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] addr;
    erase_seq_pkg::protect_cfg_s cfg;
    logic go;
    erase_seq_pkg::erase_kind_e kind;
  } row_s;

  localparam row_s ROWS [11] = '{
    '{8'h20, 24'h01_2345, 5'h00, 1'b1, erase_seq_pkg::KIND_SECT},
    '{8'h52, 24'h10_FFFF, 5'h00, 1'b1, erase_seq_pkg::KIND_HALF},
    '{8'hD8, 24'h3F_0000, 5'h00, 1'b1, erase_seq_pkg::KIND_FULL},
    '{8'hC7, 24'h00_0000, 5'h00, 1'b1, erase_seq_pkg::KIND_CHIP},
    '{8'h60, 24'h00_0000, 5'h00, 1'b1, erase_seq_pkg::KIND_CHIP},
    '{8'h20, 24'h01_2345, 5'h07, 1'b0, erase_seq_pkg::KIND_SECT},
    '{8'hC7, 24'h00_0000, 5'h01, 1'b0, erase_seq_pkg::KIND_CHIP},
    '{8'hD8, 24'h3F_0123, 5'h01, 1'b0, erase_seq_pkg::KIND_FULL},
    '{8'hD8, 24'h00_0000, 5'h01, 1'b1, erase_seq_pkg::KIND_FULL},
    '{8'h52, 24'h00_8000, 5'h09, 1'b0, erase_seq_pkg::KIND_HALF},
    '{8'h20, 24'h3F_F000, 5'h11, 1'b0, erase_seq_pkg::KIND_SECT}
  };

  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  erase_seq_pkg::protect_cfg_s cfg = 5'h00;
  erase_seq_pkg::erase_cmd_s cmd;
  logic busy;
  logic wr_latch;
  logic paused;
  logic [7:0] st;
  int n_errors = 0;
  int num_checks = 0;
  int blen = 0;
  int last_len = 0;
  int n;

  serial_flash_erase_suspend #(
    .SECT_CYC(2000), .HALF_CYC(2400), .FULL_CYC(2800), .CHIP_CYC(3200)
  ) u_serial_flash_erase_suspend (
    .mclk_i(mclk), .sys_rst_i(sys_rst), .spi_cs_n_i(cs_n),
    .spi_sclk_i(sclk), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_n_o(miso_oe_n), .protect_cfg_i(cfg),
    .erase_cmd_o(cmd), .busy_o(busy), .write_enable_latch_o(wr_latch),
    .erase_paused_flag_o(paused)
  );

  host_spi_model u_host_spi_model (
    .mclk_i(mclk), .spi_cs_n_o(cs_n), .spi_sclk_o(sclk),
    .spi_mosi_o(mosi), .spi_miso_i(miso)
  );

  initial begin
    forever #20 mclk = ~mclk;
  end

  // length of the last unbroken busy stretch
  always @(posedge mclk) begin
    if (busy === 1'b1) begin
      blen <= blen + 1;
    end else begin
      if (blen != 0) last_len <= blen;
      blen <= 0;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int cyc_of(input erase_seq_pkg::erase_kind_e k);
    return 2000 + 400 * int'(k);
  endfunction : cyc_of

  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic op8(input logic [7:0] v);
    u_host_spi_model.send8(v);
    @(negedge mclk);
  endtask : op8

  task automatic op32(input logic [31:0] v);
    u_host_spi_model.send32(v);
    @(negedge mclk);
  endtask : op32

  task automatic do_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    chk({paused, busy, wr_latch, cmd.active, miso_oe_n} === 5'h01,
        "reset");
  endtask : do_reset

  task automatic wait_idle();
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge mclk);
    repeat (2) @(negedge mclk);
  endtask : wait_idle

  initial begin
    #(40 * 90000);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    for (int i = 0; i < 11; i++) begin
      @(posedge mclk);
      cfg <= ROWS[i].cfg;
      op8(8'h06);
      if (ROWS[i].op == 8'hC7 || ROWS[i].op == 8'h60) begin
        op8(ROWS[i].op);
      end else begin
        op32({ROWS[i].op, ROWS[i].addr});
      end
      chk(busy === ROWS[i].go, "erase start");
      if (ROWS[i].go) begin
        chk(cmd.active === 1'b1 && cmd.kind === ROWS[i].kind, "kind");
        if (ROWS[i].kind != erase_seq_pkg::KIND_CHIP) begin
          chk(cmd.base === ROWS[i].addr, "erase base");
        end
        u_host_spi_model.read_status(st);
        chk(st[1:0] === 2'b11, "status while erasing");
        wait_idle();
        chk(last_len == cyc_of(ROWS[i].kind), "erase time");
        chk(wr_latch === 1'b0 && cmd.active === 1'b0, "latch kept");
      end else begin
        chk(wr_latch === 1'b1, "refused erase lost latch");
      end
    end
    // refusals with no erase running, then a pause during a whole array erase
    @(posedge mclk);
    cfg <= 5'h00;
    op8(8'h04);
    op32({8'h20, 24'h00_1000});
    chk(busy === 1'b0, "erase without latch");
    op8(8'h06);
    u_host_spi_model.send24({8'h20, 16'h1000});
    @(negedge mclk);
    chk(busy === 1'b0, "short frame ran");
    op8(8'h7A);
    chk(busy === 1'b0 && paused === 1'b0, "stray resume");
    op8(8'h75);
    chk(paused === 1'b0, "pause while idle");
    op8(8'hC7);
    op8(8'h75);
    chk(paused === 1'b0 && busy === 1'b1, "pause of array erase");
    wait_idle();
    // pause, refused erase, resume, pause again, power loss
    op8(8'h06);
    op32({8'h52, 24'h20_0000});
    op8(8'h75);
    chk(paused === 1'b1 && cmd.active === 1'b0, "pause");
    n = 0;
    while (busy === 1'b1 && n < 600) begin
      @(negedge mclk);
      n++;
    end
    chk(busy === 1'b0 && n <= 500, "pause latency");
    op32({8'h20, 24'h00_0000});
    chk(busy === 1'b0 && paused === 1'b1, "erase while paused");
    op8(8'h7A);
    chk({paused, busy, cmd.active} === 3'b011, "resume");
    op8(8'h7A);
    chk(paused === 1'b0 && busy === 1'b1, "resume while busy");
    repeat (520) @(negedge mclk);
    op8(8'h75);
    chk(paused === 1'b1, "second pause");
    do_reset();
    op8(8'h7A);
    chk(busy === 1'b0 && paused === 1'b0, "resume after loss");
    wrap_up();
  end
endmodule : serial_flash_erase_suspend_test
